// >>> shared/ssw_pkg.sv
package ssw_pkg;

   // register bus geometry
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;

   // register byte offsets
   localparam logic [11:0] DIV_OFS = 12'h400;
   localparam logic [11:0] LIT_OFS = 12'h410;
   localparam logic [11:0] SUT_OFS = 12'h420;
   localparam logic [11:0] CTRL_OFS = 12'h430;
   localparam logic [11:0] STAT_OFS = 12'h434;

   // reset values
   localparam logic [15:0] DIV_RST = 16'h09c2;
   localparam logic [15:0] LIT_RST = 16'h03e8;
   localparam logic [15:0] SUT_RST = 16'h03e8;

   // field positions
   localparam int CTRL_STATE_LSB = 0;
   localparam int STAT_STATE_LSB = 0;
   localparam int STAT_SU_TRIP_BIT = 4;
   localparam int STAT_LI_TRIP_BIT = 5;
   localparam int STAT_REJ_BIT = 8;

   // timebase: basic tick period and the offset added to the divider
   localparam int CLK_PERIOD_NS = 4;
   localparam int BASE_TICK_NS = 40;
   localparam int BASE_TICK_CYC = BASE_TICK_NS / CLK_PERIOD_NS;
   localparam logic [3:0] BASE_CNT_MAX = 4'(BASE_TICK_CYC - 1);
   localparam logic [16:0] DIV_ADD = 17'h00002;

   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // slave state machine codes
   typedef enum logic [3:0] {
      ST_INIT = 4'b0001,
      ST_PREOP = 4'b0010,
      ST_BOOT = 4'b0011,
      ST_SAFEOP = 4'b0100,
      ST_OP = 4'b1000
   } ssw_state_e;

   // axi4-lite master to slave
   typedef struct packed {
      logic awvalid;
      logic [11:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [11:0] araddr;
      logic rready;
   } ssw_axi_req_s;

   // axi4-lite slave to master
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } ssw_axi_rsp_s;

endpackage

// >>> src/ssw_wd.sv
`timescale 1ns/10ps

// one watchdog timer counting shared ticks up to its own timeout
module ssw_wd (
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // timebase and activity
   input wire logic tick_i,
   input wire logic restart_i,
   input wire logic [15:0] timeout_i,
   // result
   output logic trip_o
);

   // whole state of the timer
   typedef struct packed {
      logic [15:0] cnt; // elapsed ticks since last restart
      logic trip; // timeout reached
   } ssw_wd_s;

   ssw_wd_s s_reg;
   ssw_wd_s s_next;

   // next state: restart wins over a tick arriving in the same cycle
   always_comb begin
      s_next = s_reg;
      if (restart_i) begin
         s_next.cnt = 16'h0000;
         s_next.trip = 1'b0;
      end else if (timeout_i == 16'h0000) begin
         // zero switches the timer off completely
         s_next.cnt = 16'h0000;
         s_next.trip = 1'b0;
      end else if (tick_i && !s_reg.trip) begin
         s_next.cnt = s_reg.cnt + 16'h0001;
         if (s_next.cnt >= timeout_i) begin
            s_next.trip = 1'b1;
         end
      end
   end

   // state register
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign trip_o = s_reg.trip;

endmodule

// >>> src/ssw_top.sv
`timescale 1ns/10ps

// Operation
// - watchdog tick is multiplier plus 2 basic ticks
// - one multiplier feeds both watchdog timebases
// - each watchdog times out after its own ticks
// - multiplier resets to 2498, 100 us tick
// - sync-unit timeout resets to 1000 ticks
// - timeout 0..65535, multiplier 0..65535 accepted
// - sync-unit timeout clears live outputs
// - sync-unit timeout of zero disables watchdog
// - five states: init, preop, safeop, op, boot
// - power-on enters init, no mailbox, no data
// - init to preop needs good mailbox setup
// - preop allows mailbox, blocks process data
// - safeop entry from preop checks setup, copies inputs in the same cycle
// - safeop: traffic on, inputs cycle, outputs safe
// - disabled watchdog lets safeop drive outputs
// - op copies master data to outputs
// - boot reachable only from init
// - boot allows file transfer mailbox only
// - data access restarts watchdog, state kept
module ssw_top #(
   parameter int OUT_W = 8, // width of the physical outputs
   parameter int IN_W = 8 // width of the physical inputs
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // register bus
   input wire ssw_pkg::ssw_axi_req_s axi_req_i,
   output ssw_pkg::ssw_axi_rsp_s axi_rsp_o,
   // configuration checks from the sync channel logic
   input wire logic mbx_cfg_ok_i,
   input wire logic pd_cfg_ok_i,
   // activity strobes
   input wire logic pd_access_i,
   input wire logic local_access_i,
   // process data
   input wire logic [OUT_W-1:0] out_data_i,
   input wire logic [IN_W-1:0] in_data_i,
   output logic [OUT_W-1:0] out_o,
   output logic [IN_W-1:0] in_snap_o,
   // state and traffic permissions
   output ssw_pkg::ssw_state_e state_o,
   output logic mbx_allow_o,
   output logic foe_only_o,
   output logic pd_allow_o,
   // watchdog flags
   output logic su_trip_o,
   output logic li_trip_o
);

   // whole state of the block
   typedef struct packed {
      ssw_pkg::ssw_state_e st; // slave state
      logic [15:0] div; // watchdog_tick_divider
      logic [15:0] lit; // local_interface_timeout
      logic [15:0] sut; // sync_unit_timeout
      logic [3:0] base_cnt; // clocks within one basic tick
      logic [16:0] div_cnt; // basic ticks within one watchdog tick
      logic wd_tick; // one-cycle watchdog tick
      logic rej; // sticky: a transition was refused
      logic aw_full; // write address held
      logic w_full; // write data held
      logic [11:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      ssw_pkg::ssw_axi_rsp_s rsp; // bus answer
      logic [OUT_W-1:0] outs; // physical outputs
      logic [IN_W-1:0] snap; // input copy in the shared memory area
      logic mbx_allow;
      logic foe_only;
      logic pd_allow;
   } ssw_top_s;

   ssw_top_s s_reg;
   ssw_top_s s_next;

   logic su_trip; // sync-unit watchdog fired
   logic li_trip; // local-interface watchdog fired
   logic su_restart;

   // address compare, used by both write and read decode
   function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
      hit = (a[11:2] == o[11:2]);
   endfunction

   // merge the two low byte lanes of a write into a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0] be);
      logic [15:0] r;
      r = old;
      if (be[0]) begin
         r[7:0] = d[7:0];
      end
      if (be[1]) begin
         r[15:8] = d[15:8];
      end
      merge16 = r;
   endfunction

   // legal moves of the state machine; checks gate the two set-up steps
   function automatic logic allowed(input ssw_pkg::ssw_state_e cur,
                                    input logic [3:0] tgt,
                                    input logic mbx_ok,
                                    input logic pd_ok);
      logic ok;
      ok = 1'b0;
      if (tgt == ssw_pkg::ST_INIT) begin
         ok = 1'b1;
      end else begin
         case (cur)
            ssw_pkg::ST_INIT: begin
               ok = (tgt == ssw_pkg::ST_PREOP && mbx_ok)
                  || (tgt == ssw_pkg::ST_BOOT);
            end
            ssw_pkg::ST_PREOP: begin
               ok = (tgt == ssw_pkg::ST_PREOP)
                  || (tgt == ssw_pkg::ST_SAFEOP && pd_ok);
            end
            ssw_pkg::ST_SAFEOP: begin
               ok = (tgt == ssw_pkg::ST_PREOP)
                  || (tgt == ssw_pkg::ST_SAFEOP)
                  || (tgt == ssw_pkg::ST_OP);
            end
            ssw_pkg::ST_OP: begin
               ok = (tgt == ssw_pkg::ST_PREOP)
                  || (tgt == ssw_pkg::ST_SAFEOP)
                  || (tgt == ssw_pkg::ST_OP);
            end
            ssw_pkg::ST_BOOT: begin
               ok = (tgt == ssw_pkg::ST_BOOT);
            end
            default: begin
               ok = 1'b0;
            end
         endcase
      end
      allowed = ok;
   endfunction

   // only live outputs are guarded; elsewhere the timer is held at zero
   assign su_restart = pd_access_i || (s_reg.st != ssw_pkg::ST_OP);

   // sync-unit watchdog
   ssw_wd u_su_wd (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .tick_i(s_reg.wd_tick),
      .restart_i(su_restart),
      .timeout_i(s_reg.sut),
      .trip_o(su_trip)
   );

   // local-interface watchdog, reported only
   ssw_wd u_li_wd (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .tick_i(s_reg.wd_tick),
      .restart_i(local_access_i),
      .timeout_i(s_reg.lit),
      .trip_o(li_trip)
   );

   // next state of the whole block
   always_comb begin
      logic [31:0] rd_word;
      logic [1:0] rd_resp;
      logic [1:0] wr_resp;
      logic [3:0] tgt;
      logic req_go;
      rd_word = 32'h00000000;
      rd_resp = ssw_pkg::RESP_OKAY;
      wr_resp = ssw_pkg::RESP_OKAY;
      tgt = s_reg.wdata[ssw_pkg::CTRL_STATE_LSB +: 4];
      req_go = 1'b0;
      s_next = s_reg;

      // timebase: basic tick every BASE_TICK_CYC clocks
      s_next.wd_tick = 1'b0;
      if (s_reg.base_cnt == ssw_pkg::BASE_CNT_MAX) begin
         s_next.base_cnt = 4'h0;
         // >= so a smaller divider written mid-count cannot stall
         if ((s_reg.div_cnt + 17'h00001)
             >= ({1'b0, s_reg.div} + ssw_pkg::DIV_ADD)) begin
            s_next.div_cnt = 17'h00000;
            s_next.wd_tick = 1'b1;
         end else begin
            s_next.div_cnt = s_reg.div_cnt + 17'h00001;
         end
      end else begin
         s_next.base_cnt = s_reg.base_cnt + 4'h1;
      end

      // write channels are taken independently, in either order
      if (s_reg.rsp.awready && axi_req_i.awvalid) begin
         s_next.aw_full = 1'b1;
         s_next.awaddr = axi_req_i.awaddr;
      end
      if (s_reg.rsp.wready && axi_req_i.wvalid) begin
         s_next.w_full = 1'b1;
         s_next.wdata = axi_req_i.wdata;
         s_next.wstrb = axi_req_i.wstrb;
      end
      if (s_reg.rsp.bvalid && axi_req_i.bready) begin
         s_next.rsp.bvalid = 1'b0;
      end

      // clear of the refusal flag goes first so a new refusal wins
      if (s_reg.aw_full && s_reg.w_full && !s_reg.rsp.bvalid) begin
         s_next.aw_full = 1'b0;
         s_next.w_full = 1'b0;
         s_next.rsp.bvalid = 1'b1;
         if (hit(s_reg.awaddr, ssw_pkg::DIV_OFS)) begin
            s_next.div = merge16(s_reg.div, s_reg.wdata,
                                 s_reg.wstrb);
         end else if (hit(s_reg.awaddr, ssw_pkg::LIT_OFS)) begin
            s_next.lit = merge16(s_reg.lit, s_reg.wdata, s_reg.wstrb);
         end else if (hit(s_reg.awaddr, ssw_pkg::SUT_OFS)) begin
            s_next.sut = merge16(s_reg.sut, s_reg.wdata,
                                 s_reg.wstrb);
         end else if (hit(s_reg.awaddr, ssw_pkg::CTRL_OFS)) begin
            req_go = s_reg.wstrb[0];
         end else if (hit(s_reg.awaddr, ssw_pkg::STAT_OFS)) begin
            if (s_reg.wstrb[1] && s_reg.wdata[ssw_pkg::STAT_REJ_BIT]) begin
               s_next.rej = 1'b0;
            end
         end else begin
            wr_resp = ssw_pkg::RESP_SLVERR;
         end
         s_next.rsp.bresp = wr_resp;
      end

      // state request from software on behalf of the master
      if (req_go) begin
         if (allowed(s_reg.st, tgt, mbx_cfg_ok_i, pd_cfg_ok_i)) begin
            s_next.st = ssw_pkg::ssw_state_e'(tgt);
            if (tgt == ssw_pkg::ST_SAFEOP && s_reg.st == ssw_pkg::ST_PREOP)
            begin
               // inputs land in the same cycle as the new state
               s_next.snap = in_data_i;
            end
         end else begin
            s_next.rej = 1'b1;
         end
      end

      // read channel: one read answered at a time
      if (hit(axi_req_i.araddr, ssw_pkg::DIV_OFS)) begin
         rd_word = {16'h0000, s_reg.div};
      end else if (hit(axi_req_i.araddr, ssw_pkg::LIT_OFS)) begin
         rd_word = {16'h0000, s_reg.lit};
      end else if (hit(axi_req_i.araddr, ssw_pkg::SUT_OFS)) begin
         rd_word = {16'h0000, s_reg.sut};
      end else if (hit(axi_req_i.araddr, ssw_pkg::CTRL_OFS)) begin
         rd_word[ssw_pkg::CTRL_STATE_LSB +: 4] = s_reg.st;
      end else if (hit(axi_req_i.araddr, ssw_pkg::STAT_OFS)) begin
         rd_word[ssw_pkg::STAT_STATE_LSB +: 4] = s_reg.st;
         rd_word[ssw_pkg::STAT_SU_TRIP_BIT] = su_trip;
         rd_word[ssw_pkg::STAT_LI_TRIP_BIT] = li_trip;
         rd_word[ssw_pkg::STAT_REJ_BIT] = s_reg.rej;
      end else begin
         rd_resp = ssw_pkg::RESP_SLVERR;
      end
      if (s_reg.rsp.rvalid && axi_req_i.rready) begin
         s_next.rsp.rvalid = 1'b0;
      end
      if (s_reg.rsp.arready && axi_req_i.arvalid) begin
         s_next.rsp.rvalid = 1'b1;
         s_next.rsp.rdata = rd_word;
         s_next.rsp.rresp = rd_resp;
      end

      // readies follow the holding flags so nothing is overwritten
      s_next.rsp.awready = !s_next.aw_full;
      s_next.rsp.wready = !s_next.w_full;
      s_next.rsp.arready = !s_next.rsp.rvalid;

      // traffic permissions per state
      s_next.mbx_allow = (s_next.st != ssw_pkg::ST_INIT)
         && (s_next.st != ssw_pkg::ST_BOOT);
      s_next.foe_only = (s_next.st == ssw_pkg::ST_BOOT);
      s_next.pd_allow = (s_next.st == ssw_pkg::ST_SAFEOP)
         || (s_next.st == ssw_pkg::ST_OP);

      // inputs refresh every cycle while process data runs
      if (s_reg.st == ssw_pkg::ST_SAFEOP || s_reg.st == ssw_pkg::ST_OP)
      begin
         s_next.snap = in_data_i;
      end

      // outputs: a trip clears them but leaves the state alone
      case (s_reg.st)
         ssw_pkg::ST_OP: begin
            if (su_trip) begin
               s_next.outs = '0;
            end else begin
               s_next.outs = out_data_i;
            end
         end
         ssw_pkg::ST_SAFEOP: begin
            if (s_reg.sut == 16'h0000) begin
               s_next.outs = out_data_i;
            end else begin
               s_next.outs = '0;
            end
         end
         default: begin
            s_next.outs = '0;
         end
      endcase
   end

   // state register; resets into init with documented timing values
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         s_reg <= '0;
         s_reg.st <= ssw_pkg::ST_INIT;
         s_reg.div <= ssw_pkg::DIV_RST;
         s_reg.lit <= ssw_pkg::LIT_RST;
         s_reg.sut <= ssw_pkg::SUT_RST;
         s_reg.rsp.awready <= 1'b1;
         s_reg.rsp.wready <= 1'b1;
         s_reg.rsp.arready <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // ports straight from flip-flops
   assign axi_rsp_o = s_reg.rsp;
   assign out_o = s_reg.outs;
   assign in_snap_o = s_reg.snap;
   assign state_o = s_reg.st;
   assign mbx_allow_o = s_reg.mbx_allow;
   assign foe_only_o = s_reg.foe_only;
   assign pd_allow_o = s_reg.pd_allow;
   assign su_trip_o = su_trip;
   assign li_trip_o = li_trip;

endmodule

// >>> verif/ssw_chk_props.sv
`timescale 1ns/10ps

// passive checker on the top ports
module ssw_chk #(
   parameter int OUT_W = 8, // output width, handed on by the bind
   parameter int IN_W = 8 // input width
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // register bus
   input wire ssw_pkg::ssw_axi_req_s axi_req_i,
   input wire ssw_pkg::ssw_axi_rsp_s axi_rsp_o,
   // side inputs
   input wire logic mbx_cfg_ok_i,
   input wire logic pd_cfg_ok_i,
   input wire logic pd_access_i,
   input wire logic local_access_i,
   input wire logic [OUT_W-1:0] out_data_i,
   input wire logic [IN_W-1:0] in_data_i,
   // observed outputs
   input wire logic [OUT_W-1:0] out_o,
   input wire logic [IN_W-1:0] in_snap_o,
   input wire ssw_pkg::ssw_state_e state_o,
   input wire logic mbx_allow_o,
   input wire logic foe_only_o,
   input wire logic pd_allow_o,
   input wire logic su_trip_o,
   input wire logic li_trip_o
);
   // single domain, so one clock and one disable for all
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);

   a_boot_foe_only: assert property (
      foe_only_o == (state_o == ssw_pkg::ST_BOOT))
      else $error("file transfer flag off boot state");
   a_traffic_flags: assert property (
      pd_allow_o == (state_o inside {ssw_pkg::ST_SAFEOP, ssw_pkg::ST_OP})
      && mbx_allow_o == (state_o inside {ssw_pkg::ST_PREOP,
      ssw_pkg::ST_SAFEOP, ssw_pkg::ST_OP}))
      else $error("traffic flags disagree with state");
   // quiet states never drive the outputs after their first cycle
   a_out_idle: assert property (
      state_o inside {ssw_pkg::ST_INIT, ssw_pkg::ST_PREOP,
      ssw_pkg::ST_BOOT} && $stable(state_o) |-> out_o == '0)
      else $error("outputs live in a quiet state");
   a_op_copy: assert property (
      state_o == ssw_pkg::ST_OP && $past(state_o) == ssw_pkg::ST_OP
      && !su_trip_o && !$past(su_trip_o) |-> out_o == $past(out_data_i))
      else $error("operational outputs not copied");
   a_trip_clears: assert property (
      su_trip_o && $past(su_trip_o) |-> out_o == '0)
      else $error("outputs kept after watchdog trip");
   a_trip_in_op: assert property (
      $rose(su_trip_o) |-> $past(state_o) == ssw_pkg::ST_OP)
      else $error("sync watchdog tripped outside op");
   a_boot_from_init: assert property (
      state_o == ssw_pkg::ST_BOOT && $past(state_o) != ssw_pkg::ST_BOOT
      |-> $past(state_o) == ssw_pkg::ST_INIT)
      else $error("boot entered from a state other than init");
   // a state move only happens with a write response
   a_state_by_write: assert property (
      state_o != $past(state_o) |-> $rose(axi_rsp_o.bvalid))
      else $error("state moved without a control write");
   a_safeop_snap: assert property (
      state_o == ssw_pkg::ST_SAFEOP && $past(state_o) == ssw_pkg::ST_PREOP
      |-> in_snap_o == $past(in_data_i))
      else $error("inputs not copied on safeop entry");
endmodule

bind ssw_top ssw_chk #(.OUT_W(OUT_W), .IN_W(IN_W)) ssw_chk_i (
   .clock_i(clock_i), .rst_i(rst_i), .axi_req_i(axi_req_i),
   .axi_rsp_o(axi_rsp_o), .mbx_cfg_ok_i(mbx_cfg_ok_i),
   .pd_cfg_ok_i(pd_cfg_ok_i), .pd_access_i(pd_access_i),
   .local_access_i(local_access_i), .out_data_i(out_data_i),
   .in_data_i(in_data_i), .out_o(out_o), .in_snap_o(in_snap_o),
   .state_o(state_o), .mbx_allow_o(mbx_allow_o), .foe_only_o(foe_only_o),
   .pd_allow_o(pd_allow_o), .su_trip_o(su_trip_o), .li_trip_o(li_trip_o));

// >>> verif/ssw_master.sv
`timescale 1ns/10ps

// far-side master: channel setup and periodic data accesses
module ssw_master (
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // bench control
   input wire logic run_i,
   input wire logic [1:0] cfg_i,
   // toward the block
   output logic mbx_ok_o,
   output logic pd_ok_o,
   output logic pd_access_o,
   output logic [7:0] out_data_o
);
   logic [2:0] gap_reg; // spacing between accesses

   // setup is reported done only once the bench says so
   assign mbx_ok_o = cfg_i[0];
   assign pd_ok_o = cfg_i[1];

   // one access in eight cycles; data is valid from reset on
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         gap_reg <= 3'h0;
         pd_access_o <= 1'b0;
         out_data_o <= 8'h5a;
      end else begin
         gap_reg <= gap_reg + 3'h1;
         pd_access_o <= run_i && gap_reg == 3'h0;
         if (run_i && gap_reg == 3'h0) begin
            out_data_o <= out_data_o + 8'h11;
         end
      end
   end
endmodule

// >>> verif/tb_top.sv
`timescale 1ns/10ps

`define CHK(nm, e, a) \
   checks++; \
   if ((a) !== (e)) begin \
      error_cnt++; \
      $display("Error %s: expected %h seen %h", nm, e, a); \
   end

// bench top: bus tasks and rule scenarios
module tb_top;
   logic clock_i = 1'b0; // 250 MHz
   logic rst_i = 1'b1; // held for 16 cycles
   ssw_pkg::ssw_axi_req_s req = '0; // ready lines stay high
   ssw_pkg::ssw_axi_rsp_s rsp;
   logic run = 1'b0; // partner traffic on
   logic loc = 1'b0; // local access strobe
   logic [1:0] cfg = 2'h0; // partner setup done
   logic [7:0] din = 8'h3c; // physical inputs
   logic mbx_ok, pd_ok, pd_acc;
   logic [7:0] odata, out, snap;
   ssw_pkg::ssw_state_e st;
   logic mbx_al, foe, pd_al, su_trip, li_trip;
   logic [31:0] rd; // last read data
   logic [1:0] rs; // last response code
   int error_cnt = 0;
   int checks = 0;
   int cyc = 0;
   int n;

   always #2 clock_i = ~clock_i;

   ssw_top ssw_top_i (.clock_i(clock_i), .rst_i(rst_i), .axi_req_i(req),
      .axi_rsp_o(rsp), .mbx_cfg_ok_i(mbx_ok), .pd_cfg_ok_i(pd_ok),
      .pd_access_i(pd_acc), .local_access_i(loc), .out_data_i(odata),
      .in_data_i(din), .out_o(out), .in_snap_o(snap), .state_o(st),
      .mbx_allow_o(mbx_al), .foe_only_o(foe), .pd_allow_o(pd_al),
      .su_trip_o(su_trip), .li_trip_o(li_trip));
   ssw_master ssw_master_i (.clock_i(clock_i), .rst_i(rst_i), .run_i(run),
      .cfg_i(cfg), .mbx_ok_o(mbx_ok), .pd_ok_o(pd_ok),
      .pd_access_o(pd_acc), .out_data_o(odata));

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // the run should take under a thousand cycles; a hang ends here
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         $display("Error run time: expected end seen hang");
         complete_run();
      end
   end

   // write: address and data offered together, each dropped when taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      req.awvalid <= 1'b1;
      req.awaddr <= a;
      req.wvalid <= 1'b1;
      req.wdata <= d;
      req.wstrb <= 4'hf;
      do begin
         @(posedge clock_i);
         if (rsp.awready && req.awvalid) req.awvalid <= 1'b0;
         if (rsp.wready && req.wvalid) req.wvalid <= 1'b0;
      end while (!rsp.bvalid);
      rs = rsp.bresp;
   endtask

   task automatic rchk(input logic [11:0] a, input logic [31:0] e,
      input string nm);
      req.arvalid <= 1'b1;
      req.araddr <= a;
      do begin
         @(posedge clock_i);
         if (rsp.arready && req.arvalid) req.arvalid <= 1'b0;
      end while (!rsp.rvalid);
      rd = rsp.rdata;
      rs = rsp.rresp;
      `CHK(nm, e, rd)
   endtask

   // request a state, then let the new state land
   task automatic go(input logic [3:0] s);
      wr(ssw_pkg::CTRL_OFS, {28'h0, s});
      @(posedge clock_i);
   endtask

   // cycles until a watchdog flag rises, bounded
   task automatic wt(input logic li);
      n = 0;
      while ((li ? li_trip : su_trip) !== 1'b1 && n < 400) begin
         @(posedge clock_i);
         n++;
      end
   endtask

   initial begin
      // answers are always accepted, so bready and rready stay high
      req.bready <= 1'b1;
      req.rready <= 1'b1;
      repeat (16) @(posedge clock_i);
      rst_i <= 1'b0;
      @(posedge clock_i);
      rchk(ssw_pkg::DIV_OFS, 32'h9c2, "divider");
      rchk(ssw_pkg::SUT_OFS, 32'h3e8, "sync timeout");
      rchk(ssw_pkg::LIT_OFS, 32'h3e8, "local timeout");
      rchk(ssw_pkg::STAT_OFS, 32'h1, "status");
      rchk(12'h7fc, 32'h0, "unmapped");
      `CHK("unmapped resp", ssw_pkg::RESP_SLVERR, rs)
      wr(12'h7fc, 32'h0);
      `CHK("unmapped wr", ssw_pkg::RESP_SLVERR, rs)
      wr(ssw_pkg::DIV_OFS, 32'hffff);
      `CHK("write resp", ssw_pkg::RESP_OKAY, rs)
      rchk(ssw_pkg::DIV_OFS, 32'hffff, "divider max");
      $display("test registers done");
      go(4'h4);
      rchk(ssw_pkg::STAT_OFS, 32'h101, "refused");
      wr(ssw_pkg::STAT_OFS, 32'h100);
      go(4'h2);
      `CHK("no mailbox", ssw_pkg::ST_INIT, st)
      go(4'h3);
      `CHK("boot flag", 1'b1, foe)
      go(4'h2);
      `CHK("boot exit", ssw_pkg::ST_BOOT, st)
      go(4'h1);
      cfg <= 2'h1;
      go(4'h2);
      `CHK("preop", ssw_pkg::ST_PREOP, st)
      `CHK("preop data", 1'b0, pd_al)
      `CHK("preop mailbox", 1'b1, mbx_al)
      go(4'h3);
      `CHK("boot gate", ssw_pkg::ST_PREOP, st)
      cfg <= 2'h3;
      din <= 8'ha5;
      go(4'h4);
      `CHK("entry copy", 8'ha5, snap)
      `CHK("safe out", 8'h00, out)
      wr(ssw_pkg::SUT_OFS, 32'h0);
      din <= 8'h77;
      repeat (2) @(posedge clock_i);
      `CHK("safeop live", 8'h5a, out)
      `CHK("input cycle", 8'h77, snap)
      $display("test states done");
      // timing values are written only because this setup asks for it
      wr(ssw_pkg::DIV_OFS, 32'h1);
      wr(ssw_pkg::SUT_OFS, 32'h3);
      wr(ssw_pkg::LIT_OFS, 32'h4);
      run <= 1'b1;
      go(4'h8);
      repeat (40) @(posedge clock_i);
      `CHK("alive", 1'b0, su_trip)
      run <= 1'b0;
      repeat (3) @(posedge clock_i);
      `CHK("op copy", odata, out)
      wt(1'b0);
      `CHK("sync time", 1'b1, n >= 40 && n <= 100)
      `CHK("state kept", ssw_pkg::ST_OP, st)
      repeat (2) @(posedge clock_i);
      `CHK("cleared", 8'h00, out)
      loc <= 1'b1;
      @(posedge clock_i);
      loc <= 1'b0;
      repeat (2) @(posedge clock_i);
      `CHK("local restart", 1'b0, li_trip)
      wt(1'b1);
      `CHK("local time", 1'b1, n >= 80 && n <= 125)
      wr(ssw_pkg::SUT_OFS, 32'h0);
      repeat (300) @(posedge clock_i);
      `CHK("disabled", 1'b0, su_trip)
      // an undefined state code is refused and op is kept
      go(4'h5);
      `CHK("bad code", ssw_pkg::ST_OP, st)
      go(4'h2);
      `CHK("op to preop", ssw_pkg::ST_PREOP, st)
      `CHK("preop blocks data", 1'b0, pd_al)
      $display("test watchdogs done");
      complete_run();
   end
endmodule
